// ==== hdl/port_af_defs.svh ====
// Register offsets, reset values, masks and pin positions of the
// alternate-function multiplexer. Definitions only.
`ifndef PORT_AF_DEFS_SVH
`define PORT_AF_DEFS_SVH

// Byte addresses on the register bus, one 32-bit word each.
`define OFS_AF_A 8'h00
`define OFS_AF_B 8'h04
`define OFS_AF_C 8'h08
`define OFS_AF_D 8'h0c
`define OFS_S1_A 8'h10
`define OFS_S2_A 8'h14
`define OFS_S1_B 8'h18
`define OFS_S1_C 8'h1c
`define OFS_STAT 8'h20

// Implemented pins of each port.
`define MASK_NONE 8'h00
`define MASK_LOW6 8'h3f
`define MASK_LOW4 8'h0f
`define MASK_ALL 8'hff

// Reset values: the shared reset pin starts in its reset function.
`define RST_AF_A8 8'h04
`define RST_S2_A8 8'h04
`define RST_AF_D 1'b1

// Pin positions inside a port.
`define PIN_T0 0
`define PIN_T0O 1
`define PIN_DE 2
`define PIN_CTS 3
`define PIN_RX 4
`define PIN_TX 5
`define PIN_T1 6
`define PIN_T1O 7
`define PIN_CLK_A 1
`define PIN_CLK_B 3
`define PIN_ANALOG_INPUT_SEVEN 4
`define PIN_VREF_B 5
`define PIN_VREF_C 2
`define PIN_RST_A 2
`define ANA_HI 7
`define ANA_PA1 0

// Two-bit selections of the 8-pin port A, first select bit first.
`define SEL_00 2'b00
`define SEL_01 2'b01
`define SEL_10 2'b10
`define SEL_11 2'b11

`endif

// ==== hdl/port_af_pkg.sv ====
// Types shared by the alternate-function multiplexer and its bench.
package port_af_pkg;

    // Output level and output enable of the eight pins of one port.
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } pins_t;

    // Signals the peripherals present to the pins.
    typedef struct packed {
        logic t0_out;
        logic t0_outc;
        logic t0_in_mode;
        logic t1_out;
        logic t1_outc;
        logic t1_in_mode;
        logic uart_de;
        logic uart_txd;
        logic reset_drive;
    } periph_in_t;

    // Signals the pins hand to the peripherals.
    typedef struct packed {
        logic t0_in;
        logic t1_in;
        logic uart_cts;
        logic uart_rxd;
        logic ext_clk;
        logic ext_clk_sel;
        logic ext_reset_n;
        logic [7:0] analog_en;
        logic vref_en;
        logic [2:0] amp_en;
    } periph_out_t;

    // Whole state of the multiplexer.
    typedef struct packed {
        logic [7:0] af_a;
        logic [7:0] af_b;
        logic [7:0] af_c;
        logic af_d;
        logic [7:0] s1_a;
        logic [7:0] s2_a;
        logic [7:0] s1_b;
        logic [7:0] s1_c;
        logic done;
        logic [7:0] rdata;
        pins_t pa;
        pins_t pb;
        pins_t pc;
        pins_t pd;
        periph_out_t to_p;
    } state_t;

endpackage

// ==== hdl/port_alt_function_select.sv ====
// Alternate-function multiplexer for ports A to D with an Avalon-MM
// register slave. Assumes pin inputs already synchronous to i_core_clk
// and GPIO data and direction supplied by the port registers outside.
`timescale 1ns/10ps
`include "port_af_defs.svh"

module port_alt_function_select
    import port_af_pkg::*;
#(
    parameter int PIN_COUNT = 28
) (
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic [7:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    input wire logic [3:0] i_byteenable,
    output logic [31:0] o_readdata,
    output logic o_waitrequest,
    input wire logic [7:0] i_pin_a,
    input wire logic [7:0] i_pin_b,
    input wire logic [7:0] i_pin_c,
    input wire logic [7:0] i_pin_d,
    input wire pins_t i_gpio_a,
    input wire pins_t i_gpio_b,
    input wire pins_t i_gpio_c,
    input wire pins_t i_gpio_d,
    input wire periph_in_t i_periph,
    output pins_t o_pin_a,
    output pins_t o_pin_b,
    output pins_t o_pin_c,
    output pins_t o_pin_d,
    output periph_out_t o_periph
);

    localparam bit IS8 = (PIN_COUNT == 8);
    localparam bit IS20 = (PIN_COUNT == 20);
    localparam bit IS28 = (PIN_COUNT == 28);
    localparam logic [7:0] MASK_A = IS8 ? `MASK_LOW6 : `MASK_ALL;
    localparam logic [7:0] MASK_B =
        IS8 ? `MASK_NONE : (IS20 ? `MASK_LOW4 : `MASK_ALL);
    localparam logic [7:0] MASK_C =
        IS8 ? `MASK_NONE : (IS20 ? `MASK_LOW4 : `MASK_ALL);
    // Select registers of port A exist only on the 8-pin part.
    localparam logic [7:0] MASK_SA = IS8 ? `MASK_LOW6 : `MASK_NONE;

    state_t q;
    state_t n;
    logic req;
    logic acc;

    // A request waits exactly one cycle, then completes.
    assign req = i_read | i_write;
    assign acc = req & q.done;
    assign o_waitrequest = req & ~q.done;
    assign o_readdata = {24'h000000, q.rdata};
    assign o_pin_a = q.pa;
    assign o_pin_b = q.pb;
    assign o_pin_c = q.pc;
    assign o_pin_d = q.pd;
    assign o_periph = q.to_p;

    // Bus decode, selection of each pin and its registered outputs.
    always_comb begin
        logic [1:0] s0;
        logic [1:0] s1;
        logic [1:0] s2;
        logic [1:0] s3;
        logic [7:0] a;
        logic [7:0] b;
        logic [7:0] bs;
        logic t0i;
        logic t0c;
        logic t0o;
        logic clk_a;
        logic ana_a;
        logic de;
        logic rst_a;
        logic t1o_a;
        logic cts;
        logic rx;
        logic tx;
        logic clk_b;
        s0 = 2'b00;
        s1 = 2'b00;
        s2 = 2'b00;
        s3 = 2'b00;
        a = 8'h00;
        b = 8'h00;
        bs = 8'h00;
        t0i = 1'b0;
        t0c = 1'b0;
        t0o = 1'b0;
        clk_a = 1'b0;
        ana_a = 1'b0;
        de = 1'b0;
        rst_a = 1'b0;
        t1o_a = 1'b0;
        cts = 1'b0;
        rx = 1'b0;
        tx = 1'b0;
        clk_b = 1'b0;
        n = q;
        n.done = req & ~q.done;

        // Read data is captured in the waiting cycle.
        if (req & ~q.done) begin
            case (i_address)
                `OFS_AF_A: n.rdata = q.af_a;
                `OFS_AF_B: n.rdata = q.af_b;
                `OFS_AF_C: n.rdata = q.af_c;
                `OFS_AF_D: n.rdata = {7'h00, q.af_d};
                `OFS_S1_A: n.rdata = q.s1_a;
                `OFS_S2_A: n.rdata = q.s2_a;
                `OFS_S1_B: n.rdata = q.s1_b;
                `OFS_S1_C: n.rdata = q.s1_c;
                `OFS_STAT: n.rdata = {5'h00, q.to_p.ext_reset_n,
                    q.to_p.vref_en, q.to_p.ext_clk_sel};
                default: n.rdata = 8'h00;
            endcase
        end

        // Writes land on the completing edge; missing pins stay zero.
        if (i_write & acc & i_byteenable[0]) begin
            case (i_address)
                `OFS_AF_A: n.af_a = i_writedata[7:0] & MASK_A;
                `OFS_AF_B: n.af_b = i_writedata[7:0] & MASK_B;
                `OFS_AF_C: n.af_c = i_writedata[7:0] & MASK_C;
                `OFS_AF_D: n.af_d = i_writedata[0] & ~IS8;
                `OFS_S1_A: n.s1_a = i_writedata[7:0] & MASK_SA;
                `OFS_S2_A: n.s2_a = i_writedata[7:0] & MASK_SA;
                `OFS_S1_B: n.s1_b = i_writedata[7:0] & MASK_B;
                `OFS_S1_C: n.s1_c = i_writedata[7:0] & MASK_C;
                default: ;
            endcase
        end

        // GPIO owns a pin unless its enable bit hands it over; a handed
        // over pin is released until a peripheral claims it.
        n.pa = i_gpio_a;
        n.pb = i_gpio_b;
        n.pc = i_gpio_c;
        n.pd = i_gpio_d;
        n.pa.out = i_gpio_a.out & ~q.af_a;
        n.pa.oe = i_gpio_a.oe & ~q.af_a;
        n.pb.out = i_gpio_b.out & ~q.af_b;
        n.pb.oe = i_gpio_b.oe & ~q.af_b;
        n.pc.out = i_gpio_c.out & ~q.af_c;
        n.pc.oe = i_gpio_c.oe & ~q.af_c;
        n.to_p = '0;

        // Port A decode; on the 8-pin part both select bits pick.
        a = q.af_a;
        s0 = {q.s1_a[`PIN_T0], q.s2_a[`PIN_T0]};
        s1 = {q.s1_a[`PIN_T0O], q.s2_a[`PIN_T0O]};
        s2 = {q.s1_a[`PIN_DE], q.s2_a[`PIN_DE]};
        s3 = {q.s1_a[`PIN_CTS], q.s2_a[`PIN_CTS]};
        t0i = a[`PIN_T0] & (IS8 ? s0 == `SEL_00
            : i_periph.t0_in_mode);
        t0c = a[`PIN_T0] & (IS8 ? s0 == `SEL_11
            : ~i_periph.t0_in_mode);
        t0o = a[`PIN_T0O] & (~IS8 | s1 == `SEL_00);
        clk_a = IS8 & a[`PIN_CLK_A] & s1 == `SEL_10;
        ana_a = IS8 & a[`PIN_CLK_A] & s1 == `SEL_11;
        de = a[`PIN_DE] & (~IS8 | s2 == `SEL_00);
        rst_a = IS8 & a[`PIN_RST_A] & s2 == `SEL_01;
        t1o_a = IS8 & a[`PIN_DE] & s2 == `SEL_10;
        cts = a[`PIN_CTS] & (~IS8 | s3 == `SEL_00);
        rx = a[`PIN_RX] & (~IS8 | ({q.s1_a[`PIN_RX],
            q.s2_a[`PIN_RX]} == `SEL_00));
        tx = a[`PIN_TX] & (~IS8 | ({q.s1_a[`PIN_TX],
            q.s2_a[`PIN_TX]} == `SEL_00));

        // Timer 0 on bits 0 and 1, complement drives only as output.
        n.to_p.t0_in = t0i & i_pin_a[`PIN_T0];
        if (t0c) begin
            n.pa.out[`PIN_T0] = i_periph.t0_outc;
            n.pa.oe[`PIN_T0] = 1'b1;
        end
        if (t0o) begin
            n.pa.out[`PIN_T0O] = i_periph.t0_out;
            n.pa.oe[`PIN_T0O] = 1'b1;
        end

        // Shared bit 2: driver enable, or on 8-pin reset or timer 1.
        if (de) begin
            n.pa.out[`PIN_DE] = i_periph.uart_de;
            n.pa.oe[`PIN_DE] = 1'b1;
        end
        if (t1o_a) begin
            n.pa.out[`PIN_DE] = i_periph.t1_out;
            n.pa.oe[`PIN_DE] = 1'b1;
        end
        if (rst_a) begin
            n.pa.oe[`PIN_RST_A] = i_periph.reset_drive;
        end

        // UART handshake and data.
        n.to_p.uart_cts = cts & i_pin_a[`PIN_CTS];
        n.to_p.uart_rxd = rx & i_pin_a[`PIN_RX];
        if (tx) begin
            n.pa.out[`PIN_TX] = i_periph.uart_txd;
            n.pa.oe[`PIN_TX] = 1'b1;
        end

        // Timer 1 on bits 6 and 7, only present above 8 pins.
        if (~IS8 & a[`PIN_T1]) begin
            n.to_p.t1_in = i_periph.t1_in_mode
                & i_pin_a[`PIN_T1];
            n.pa.out[`PIN_T1] = i_periph.t1_outc;
            n.pa.oe[`PIN_T1] = ~i_periph.t1_in_mode;
        end
        if (~IS8 & a[`PIN_T1O]) begin
            n.pa.out[`PIN_T1O] = i_periph.t1_out;
            n.pa.oe[`PIN_T1O] = 1'b1;
        end

        // Port B: only the first select bit counts, and only while the
        // enable bit is set; a cleared select picks the clock on bit 3 and is reserved elsewhere.
        b = q.af_b;
        bs = q.af_b & q.s1_b;
        clk_b = b[`PIN_CLK_B] & ~q.s1_b[`PIN_CLK_B];
        n.to_p.analog_en[3:0] = bs[3:0];
        n.to_p.analog_en[`ANA_HI] = bs[`PIN_ANALOG_INPUT_SEVEN];
        n.to_p.amp_en = bs[2:0];
        if (ana_a) begin
            n.to_p.analog_en[`ANA_PA1] = 1'b1;
        end

        // Reference pin differs with the package.
        n.to_p.vref_en = (IS28 & bs[`PIN_VREF_B])
            | (IS20 & q.af_c[`PIN_VREF_C]
            & q.s1_c[`PIN_VREF_C]) | ana_a;

        // External clock source: port B on larger parts, else port A.
        n.to_p.ext_clk_sel = clk_b | clk_a;
        if (clk_b) begin
            n.to_p.ext_clk = i_pin_b[`PIN_CLK_B];
        end else if (clk_a) begin
            n.to_p.ext_clk = i_pin_a[`PIN_CLK_A];
        end

        // Reset pin is open drain: it only ever pulls low.
        n.to_p.ext_reset_n = 1'b1;
        if (rst_a) begin
            n.to_p.ext_reset_n = i_pin_a[`PIN_RST_A];
        end
        if (q.af_d) begin
            n.pd.out[0] = 1'b0;
            n.pd.oe[0] = i_periph.reset_drive;
            n.to_p.ext_reset_n = i_pin_d[0];
        end
    end

    // State register; the reset pin comes up in its reset function.
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            q <= '0;
            q.af_a <= IS8 ? `RST_AF_A8 : `MASK_NONE;
            q.s2_a <= IS8 ? `RST_S2_A8 : `MASK_NONE;
            q.af_d <= IS8 ? 1'b0 : `RST_AF_D;
            q.to_p.ext_reset_n <= 1'b1;
        end else begin
            q <= n;
        end
    end

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rstn);

    sequence clk_b_picked;
        !IS8 && q.af_b[`PIN_CLK_B] && !q.s1_b[`PIN_CLK_B];
    endsequence

    sequence write_af_b;
        i_write && !o_waitrequest && i_byteenable[0]
            && i_address == `OFS_AF_B;
    endsequence

    a_clk_from_b: assert property (
        clk_b_picked |=> o_periph.ext_clk_sel
            && o_periph.ext_clk == $past(i_pin_b[`PIN_CLK_B]))
        else $error("clock not taken from port B bit three");

    a_clk_ana_b: assert property (
        q.af_b[`PIN_CLK_B] && q.s1_b[`PIN_CLK_B] |=>
            o_periph.analog_en[`PIN_CLK_B] && !o_periph.ext_clk_sel)
        else $error("select set on clock pin did not give ADC");

    a_clk_from_a: assert property (
        IS8 && q.af_a[`PIN_CLK_A] && q.s1_a[`PIN_CLK_A]
            && !q.s2_a[`PIN_CLK_A] |=>
            o_periph.ext_clk == $past(i_pin_a[`PIN_CLK_A]))
        else $error("8-pin clock not taken from port A bit one");

    a_no_sel_a: assert property (
        !IS8 |-> q.s1_a == 8'h00 && q.s2_a == 8'h00)
        else $error("port A select register holds bits");

    a_tx_direct: assert property (
        !IS8 && q.af_a[`PIN_TX] |=> o_pin_a.oe[`PIN_TX]
            && o_pin_a.out[`PIN_TX] == $past(i_periph.uart_txd))
        else $error("transmit pin not connected to UART");

    a_timer_mode: assert property (
        !IS8 && q.af_a[`PIN_T0] |=> o_pin_a.oe[`PIN_T0]
            == !$past(i_periph.t0_in_mode))
        else $error("timer 0 pin direction ignores timer mode");

    a_ana_select: assert property (
        write_af_b ##1 (q.af_b[`PIN_ANALOG_INPUT_SEVEN] && q.s1_b[`PIN_ANALOG_INPUT_SEVEN])
            |=> o_periph.analog_en[`ANA_HI])
        else $error("ADC input seven not selected");

    a_af_b_write: assert property (
        write_af_b |=> q.af_b == ($past(i_writedata[7:0]) & MASK_B))
        else $error("port B enable write lost");

    a_sel_alone: assert property (
        !q.af_b[`PIN_ANALOG_INPUT_SEVEN] |=> !o_periph.analog_en[`ANA_HI])
        else $error("select bit alone connected the ADC");

    // The edge that releases reset still finds the flops in reset, so an
    // attempt started there would compare against stale reset values.
    a_reset_pd: assert property (
        i_rstn && !IS8 && q.af_d |=>
            o_periph.ext_reset_n == $past(i_pin_d[0]) && !o_pin_d.out[0])
        else $error("port D bit zero not the external reset");

    a_reserved_b: assert property (
        q.af_b[`PIN_T1] |=> !o_pin_b.oe[`PIN_T1])
        else $error("reserved port B pin driven");

endmodule // port_alt_function_select

// ==== bench/periph_model.sv ====
// Stand-in for the timers, UART and reset logic beside the pin mux.
// Assumes the bench sets the wanted peripheral levels between edges.
`timescale 1ns/10ps
module periph_model
    import port_af_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire periph_in_t i_want,
    input wire periph_out_t i_from_pins,
    output periph_in_t o_periph,
    output logic o_osc_ext
);
    // Peripherals drive their pin signals from flops, so they lag a cycle.
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_periph <= '0;
            o_osc_ext <= 1'b0;
        end else begin
            o_periph <= i_want;
            // The clock source only moves over once the pin is routed.
            o_osc_ext <= i_from_pins.ext_clk_sel;
        end
    end
endmodule // periph_model

// ==== bench/testbench.sv ====
// Self-checking bench: three package variants of the pin mux share one bus.
// Assumes the mux answers each bus access by dropping waitrequest.
`timescale 1ns/10ps
`include "port_af_defs.svh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
    num_errors++; $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module testbench
    import port_af_pkg::*;
;
    typedef struct packed {
        logic [7:0] af, s1, pin;
        logic sel, clk;
        logic [7:0] ana;
        logic vref;
        logic [2:0] amp;
    } row_t;
    logic i_core_clk, i_rstn, i_read, i_write, wait28, osc_ext;
    logic [7:0] i_address, i_pin_a, i_pin_b, i_pin_c, i_pin_d;
    logic [31:0] i_writedata, rd28, rd20, rd8, r28, r20, r8;
    logic [3:0] i_byteenable;
    pins_t i_gpio_a, i_gpio_b, i_gpio_c, i_gpio_d, pa28, pb28, pd28;
    periph_in_t i_periph, want;
    periph_out_t po28, po20, po8;
    int num_errors = 0, tests_run = 0, cycles = 0;
    row_t r;
    // Port B rows: enable, first select, pin level and the routing expected.
    row_t rows[7] = '{
        '{8'h08, 8'h00, 8'h08, 1'b1, 1'b1, 8'h00, 1'b0, 3'h0},
        '{8'h08, 8'h00, 8'hf7, 1'b1, 1'b0, 8'h00, 1'b0, 3'h0},
        '{8'h08, 8'h08, 8'h08, 1'b0, 1'b0, 8'h08, 1'b0, 3'h0},
        '{8'h00, 8'hff, 8'hff, 1'b0, 1'b0, 8'h00, 1'b0, 3'h0},
        '{8'hff, 8'hff, 8'h00, 1'b0, 1'b0, 8'h8f, 1'b1, 3'h7},
        '{8'hff, 8'h00, 8'hff, 1'b1, 1'b1, 8'h00, 1'b0, 3'h0},
        '{8'h17, 8'h17, 8'h00, 1'b0, 1'b0, 8'h87, 1'b0, 3'h7}};

    port_alt_function_select #(.PIN_COUNT(28)) i_port_alt_function_select_28 (
        .i_core_clk, .i_rstn, .i_address, .i_read, .i_write, .i_writedata,
        .i_byteenable, .i_pin_a, .i_pin_b, .i_pin_c, .i_pin_d, .i_gpio_a,
        .i_gpio_b, .i_gpio_c, .i_gpio_d, .i_periph, .o_readdata(rd28),
        .o_waitrequest(wait28), .o_pin_a(pa28), .o_pin_b(pb28), .o_pin_c(),
        .o_pin_d(pd28), .o_periph(po28));
    port_alt_function_select #(.PIN_COUNT(20)) i_port_alt_function_select_20 (
        .i_core_clk, .i_rstn, .i_address, .i_read, .i_write, .i_writedata,
        .i_byteenable, .i_pin_a, .i_pin_b, .i_pin_c, .i_pin_d, .i_gpio_a,
        .i_gpio_b, .i_gpio_c, .i_gpio_d, .i_periph, .o_readdata(rd20),
        .o_waitrequest(), .o_pin_a(), .o_pin_b(), .o_pin_c(), .o_pin_d(),
        .o_periph(po20));
    port_alt_function_select #(.PIN_COUNT(8)) i_port_alt_function_select_8 (
        .i_core_clk, .i_rstn, .i_address, .i_read, .i_write, .i_writedata,
        .i_byteenable, .i_pin_a, .i_pin_b, .i_pin_c, .i_pin_d, .i_gpio_a,
        .i_gpio_b, .i_gpio_c, .i_gpio_d, .i_periph, .o_readdata(rd8),
        .o_waitrequest(), .o_pin_a(), .o_pin_b(), .o_pin_c(), .o_pin_d(),
        .o_periph(po8));
    periph_model i_periph_model (.i_core_clk, .i_rstn, .i_want(want),
        .i_from_pins(po28), .o_periph(i_periph), .o_osc_ext(osc_ext));

    // 20 MHz core clock.
    initial begin
        i_core_clk = 1'b0;
        forever #25 i_core_clk = ~i_core_clk;
    end

    // A hung handshake would stall the run, so cycles are capped.
    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            end_of_test();
        end
    end

    task end_of_test;
        $display("errors %0d of %0d checks", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // One Avalon access; read data of all three variants taken at the
    // edge where waitrequest is seen low.
    // A stuck waitrequest is caught by the cycle cap, not here.
    task bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        i_address <= a;
        i_read <= !wr;
        i_write <= wr;
        i_writedata <= {24'h0, d};
        do begin
            @(posedge i_core_clk);
        end while (wait28 !== 1'b0);
        r28 = rd28;
        r20 = rd20;
        r8 = rd8;
        i_read <= 1'b0;
        i_write <= 1'b0;
    endtask

    // Outputs lag the peripheral flops by one edge; three edges cover both.
    task settle;
        repeat (3) @(posedge i_core_clk);
        #1;
    endtask

    task do_reset;
        @(posedge i_core_clk);
        i_rstn <= 1'b0;
        repeat (6) @(posedge i_core_clk);
        i_rstn <= 1'b1;
    endtask

    initial begin
        i_rstn = 1'b0;
        {i_read, i_write, i_address, i_writedata} = '0;
        i_byteenable = 4'h1;
        {i_pin_a, i_pin_b, i_pin_c, i_pin_d} = '0;
        {i_gpio_a, i_gpio_b, i_gpio_c, i_gpio_d} = '0;
        // Port B GPIO drives every pin, so a handed-over pin shows as cut.
        i_gpio_b = '{out: 8'hff, oe: 8'hff};
        want = '0;
        do_reset();
        foreach (rows[i]) begin
            r = rows[i];
            bus(1'b1, `OFS_AF_B, 8'h00);
            bus(1'b1, `OFS_S1_B, r.s1);
            bus(1'b1, `OFS_AF_B, r.af);
            i_pin_b <= r.pin;
            settle();
            `CHK("clk_sel", r.sel, po28.ext_clk_sel)
            if (r.sel) `CHK("ext_clk", r.clk, po28.ext_clk)
            `CHK("analog_en", r.ana, po28.analog_en)
            `CHK("vref_en", r.vref, po28.vref_en)
            `CHK("amp_en", r.amp, po28.amp_en)
            `CHK("osc_ext", r.sel, osc_ext)
            `CHK("pb oe", ~r.af, pb28.oe)
        end
        // Register map, read-only masks and an unmapped address.
        do_reset();
        bus(1'b0, `OFS_AF_D, 8'h00);
        `CHK("af_d rst", 32'h1, r28)
        bus(1'b0, `OFS_AF_A, 8'h00);
        `CHK("af_a rst8", 32'h4, r8)
        bus(1'b1, `OFS_S1_A, 8'hff);
        bus(1'b0, `OFS_S1_A, 8'h00);
        `CHK("s1_a 28", 32'h0, r28)
        `CHK("s1_a 8", 32'h3f, r8)
        bus(1'b1, `OFS_S2_A, 8'hff);
        bus(1'b0, `OFS_S2_A, 8'h00);
        `CHK("s2_a 28", 32'h0, r28)
        bus(1'b0, 8'h24, 8'h00);
        `CHK("unmapped", 32'h0, r20)
        // Small package: clock input moves to port A bit one.
        bus(1'b1, `OFS_S1_A, 8'h02);
        bus(1'b1, `OFS_S2_A, 8'h04);
        bus(1'b1, `OFS_AF_A, 8'h06);
        i_pin_a <= 8'h02;
        bus(1'b1, `OFS_S1_C, 8'h04);
        bus(1'b1, `OFS_AF_C, 8'h04);
        settle();
        `CHK("clk8 sel", 1'b1, po8.ext_clk_sel)
        `CHK("clk8", 1'b1, po8.ext_clk)
        `CHK("clk28 sel", 1'b0, po28.ext_clk_sel)
        `CHK("vref20", 1'b1, po20.vref_en)
        `CHK("vref28", 1'b0, po28.vref_en)
        bus(1'b0, `OFS_STAT, 8'h00);
        `CHK("stat 8", 32'h1, r8)
        `CHK("stat 20", 32'h2, r20)
        // Shared reset pin stays in its reset function after reset.
        do_reset();
        want.reset_drive <= 1'b1;
        i_gpio_d <= '{out: 8'h01, oe: 8'h00};
        settle();
        `CHK("rst_n", 1'b0, po28.ext_reset_n)
        `CHK("pd oe", 1'b1, pd28.oe[0])
        // Released by the reset logic, the pin rises to its pull-up.
        want.reset_drive <= 1'b0;
        i_pin_d <= 8'h01;
        settle();
        `CHK("rst_n pin", 1'b1, po28.ext_reset_n)
        `CHK("pd release", 1'b0, pd28.oe[0])
        i_pin_d <= 8'h00;
        bus(1'b1, `OFS_AF_D, 8'h00);
        settle();
        `CHK("rst_n off", 1'b1, po28.ext_reset_n)
        `CHK("pd gpio", 8'h00, pd28.oe)
        // Port A single functions under both timer modes.
        do_reset();
        i_gpio_a <= '{out: 8'h55, oe: 8'hff};
        i_pin_a <= 8'h59;
        want <= '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
        bus(1'b1, `OFS_AF_A, 8'hff);
        for (int m = 1; m >= 0; m--) begin
            want.t0_in_mode <= m[0];
            want.t1_in_mode <= m[0];
            settle();
            `CHK("pa oe", m ? 8'ha6 : 8'he7, pa28.oe)
            `CHK("pa out", 8'h46, pa28.out)
            `CHK("pa in", m ? 4'hf : 4'h3, {po28.t0_in, po28.t1_in,
                po28.uart_cts, po28.uart_rxd})
        end
        end_of_test();
    end
endmodule // testbench
